// ### inc/tlrc_pkg.sv
// constants for the transceiver loopback and reset controller
// assumes a single 200 MHz core clock and the plain register port
package tlrc_pkg;
  // register offsets on the plain port
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] STATUS_OFS   = 8'h04;
  localparam logic [7:0] PREEMPH_OFS  = 8'h08;
  // control field positions
  localparam int CTRL_MODE_LSB        = 0;   // two bits
  localparam int CTRL_SER_LPBK_BIT    = 2;
  localparam int CTRL_REV_SER_BIT     = 3;
  localparam int CTRL_PRE_CDR_BIT     = 4;
  localparam int CTRL_PSTATE_LSB      = 5;   // two bits
  localparam int CTRL_DETRX_LPBK_BIT  = 7;
  localparam int CTRL_TX_DIG_RST_BIT  = 8;
  localparam int CTRL_RX_ANA_RST_BIT  = 9;
  localparam int CTRL_RX_DIG_RST_BIT  = 10;
  localparam int CTRL_POWERDOWN_BIT   = 11;
  localparam int CTRL_BLK_ENABLE_BIT  = 12;
  localparam int CTRL_CAL_PD_BIT      = 13;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_1700;
  // status field positions
  localparam int STAT_LB_LSB          = 0;   // three bits
  localparam int STAT_CNT_LSB         = 4;   // four bits
  localparam int STAT_TX_OE_BIT       = 8;
  localparam int STAT_OVF_BIT         = 9;
  // functional modes
  localparam logic [1:0] MODE_BASIC   = 2'h0;
  localparam logic [1:0] MODE_GIGE    = 2'h1;
  localparam logic [1:0] MODE_SRIO    = 2'h2;
  localparam logic [1:0] MODE_PIPE    = 2'h3;
  localparam logic [1:0] PSTATE_P0    = 2'h0;
  // receive phase fifo depths
  localparam logic [3:0] FIFO_DEPTH_PIPE  = 4'h8;
  localparam logic [3:0] FIFO_DEPTH_OTHER = 4'h4;
  localparam int         FIFO_MAX         = 8;
  // loopback path, gray along none-serial-reverse-parallel
  typedef enum logic [2:0] {
    LB_NONE    = 3'h0,
    LB_SERIAL  = 3'h1,
    LB_REV_PAR = 3'h3,
    LB_REV_SER = 3'h2,
    LB_PRE_CDR = 3'h6
  } tlrc_lb_e;
endpackage : tlrc_pkg

// ### rtl/tlrc_top.sv
// one transceiver channel: loopback path select, resets, block powerdown
// assumes synchronous inputs, one clock, and a master that never waits
// Behaviour
// - In GIGE and SRIO modes, with reverse serial and pre-CDR off, the serial loopback enable puts the channel in serial loopback while high and out while low.
// - In serial loopback the whole transmit and receive datapaths run as in normal operation.
// - In serial loopback the transmit output buffer stays enabled and still drives the serializer output.
// - Reverse serial loopback retimes received data through clock recovery and sends it out of the transmit buffer.
// - Pre-CDR reverse loopback returns received data before clock recovery and ignores pre-emphasis.
// - Reverse parallel loopback exists only in PIPE mode.
// - Reverse parallel loopback is entered on a high receiver-detect/loopback request only in power state P0.
// - In reverse parallel loopback the rate matcher output feeds the serializer and the transmit pin.
// - In reverse parallel loopback the rate matcher output still reaches the fabric through decoder and phase fifo.
// - Each channel has independent transmit digital, receive analog and receive digital resets.
// - Block powerdown and block enable shut down the datapaths and the transmit buffer; tx_preemph still drives the pre-emphasis setting.
// - The receive phase fifo holds eight words in PIPE mode and four otherwise.
`timescale 1ns/1ps
module tlrc_top
  import tlrc_pkg::*;
#(
  parameter int W = 10
) (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic [7:0]   reg_addr,
  input  wire logic [31:0]  reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic [31:0]       reg_rdata,
  input  wire logic [W-1:0] tx_data,
  input  wire logic         tx_valid,
  input  wire logic [W-1:0] rx_serial_in,
  input  wire logic         rx_serial_valid,
  output logic [W-1:0]      tx_serial_out,
  output logic              tx_buf_oe,
  output logic [3:0]        tx_preemph,
  input  wire logic         rx_ready,
  output logic [W-1:0]      rx_data,
  output logic              rx_valid,
  output logic              cal_powerdown
);
  initial begin
    if (W < 1 || W > 20) $error("W must be 1..20");
  end

  typedef struct packed {
    logic [31:0]                  ctrl;
    logic [3:0]                   preemph;
    logic [31:0]                  rdata;
    logic [W-1:0]                 txp;     // transmit pcs stage
    logic                         txp_v;
    logic [W-1:0]                 ser;     // serializer output
    logic                         ser_v;
    logic [W-1:0]                 clock_recovery_unit;     // clock recovery output
    logic                         cru_v;
    logic [W-1:0]                 rm;      // aligner and rate matcher output
    logic                         rm_v;
    logic [W-1:0]                 dec;     // decoder / byte deserializer output
    logic                         dec_v;
    logic [FIFO_MAX-1:0][W-1:0]   mem;
    logic [2:0]                   wp;
    logic [2:0]                   rp;
    logic [3:0]                   cnt;
    logic                         ovf;
    logic [W-1:0]                 tx_out;
    logic                         tx_oe;
    logic [3:0]                   pe_out;
    logic [W-1:0]                 rx_d;
    logic                         rx_v;
    tlrc_lb_e                     lb;
  } tlrc_state_s;

  tlrc_state_s st_r;
  tlrc_state_s st_nxt;

  function automatic tlrc_lb_e pick_lb(input logic [31:0] c);
    logic [1:0] md;
    md = c[CTRL_MODE_LSB +: 2];
    if (c[CTRL_PRE_CDR_BIT])
      pick_lb = LB_PRE_CDR;
    else if (c[CTRL_REV_SER_BIT])
      pick_lb = LB_REV_SER;
    else if (md == MODE_PIPE && c[CTRL_DETRX_LPBK_BIT]
             && c[CTRL_PSTATE_LSB +: 2] == PSTATE_P0)
      pick_lb = LB_REV_PAR;
    else if ((md == MODE_GIGE || md == MODE_SRIO) && c[CTRL_SER_LPBK_BIT])
      pick_lb = LB_SERIAL;
    else
      pick_lb = LB_NONE;
  endfunction : pick_lb

  logic       blk_off;
  logic       tx_drst;
  logic       rx_arst;
  logic       rx_drst;
  logic [3:0] depth;
  logic       push;
  logic       pop;
  tlrc_lb_e   lb_now;

  always_comb begin
    st_nxt  = st_r;
    blk_off = st_r.ctrl[CTRL_POWERDOWN_BIT] || !st_r.ctrl[CTRL_BLK_ENABLE_BIT];
    tx_drst = st_r.ctrl[CTRL_TX_DIG_RST_BIT] || blk_off;
    rx_arst = st_r.ctrl[CTRL_RX_ANA_RST_BIT] || blk_off;
    rx_drst = st_r.ctrl[CTRL_RX_DIG_RST_BIT] || blk_off;
    depth   = (st_r.ctrl[CTRL_MODE_LSB +: 2] == MODE_PIPE) ?
              FIFO_DEPTH_PIPE : FIFO_DEPTH_OTHER;
    lb_now  = pick_lb(st_r.ctrl);
    st_nxt.lb = lb_now;

    // register port; read data appear only in the following cycle
    st_nxt.rdata = '0;
    if (reg_wr) begin
      unique case (reg_addr)
        CTRL_OFS:    st_nxt.ctrl    = reg_wdata;
        PREEMPH_OFS: st_nxt.preemph = reg_wdata[3:0];
        STATUS_OFS:  if (reg_wdata[STAT_OVF_BIT]) st_nxt.ovf = 1'b0;
        default:     ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        CTRL_OFS:    st_nxt.rdata = st_r.ctrl;
        PREEMPH_OFS: st_nxt.rdata = {28'h0, st_r.preemph};
        STATUS_OFS: begin
          st_nxt.rdata[STAT_LB_LSB +: 3]  = st_r.lb;
          st_nxt.rdata[STAT_CNT_LSB +: 4] = st_r.cnt;
          st_nxt.rdata[STAT_TX_OE_BIT]    = st_r.tx_oe;
          st_nxt.rdata[STAT_OVF_BIT]      = st_r.ovf;
        end
        default:     st_nxt.rdata = '0;
      endcase
    end

    // transmit pcs runs the same in every loopback
    st_nxt.txp   = tx_drst ? '0 : tx_data;
    st_nxt.txp_v = !tx_drst && tx_valid;
    // serializer takes rate matcher output in reverse parallel loopback
    if (st_r.lb == LB_REV_PAR) begin
      st_nxt.ser   = st_r.rm;
      st_nxt.ser_v = st_r.rm_v;
    end else begin
      st_nxt.ser   = st_r.txp;
      st_nxt.ser_v = st_r.txp_v;
    end
    if (blk_off) begin
      st_nxt.ser   = '0;
      st_nxt.ser_v = 1'b0;
    end

    // clock recovery sees the serializer in serial loopback
    if (rx_arst) begin
      st_nxt.clock_recovery_unit   = '0;
      st_nxt.cru_v = 1'b0;
    end else if (st_r.lb == LB_SERIAL) begin
      st_nxt.clock_recovery_unit   = st_r.ser;
      st_nxt.cru_v = st_r.ser_v;
    end else begin
      st_nxt.clock_recovery_unit   = rx_serial_in;
      st_nxt.cru_v = rx_serial_valid;
    end

    // receive pcs unchanged by loopback; feeds fabric in every mode
    st_nxt.rm    = rx_drst ? '0 : st_r.clock_recovery_unit;
    st_nxt.rm_v  = !rx_drst && st_r.cru_v;
    st_nxt.dec   = rx_drst ? '0 : st_r.rm;
    st_nxt.dec_v = !rx_drst && st_r.rm_v;

    // phase fifo; a word arriving at a full fifo is dropped and flagged
    push = st_r.dec_v && (st_r.cnt < depth);
    pop  = (st_r.cnt != 4'h0) && rx_ready;
    if (st_r.dec_v && !push) st_nxt.ovf = 1'b1;   // set wins over software clear
    if (push) begin
      st_nxt.mem[st_r.wp] = st_r.dec;
      st_nxt.wp = (st_r.wp + 3'h1) & 3'(depth - 4'h1);
    end
    if (pop) begin
      st_nxt.rp = (st_r.rp + 3'h1) & 3'(depth - 4'h1);
    end
    st_nxt.cnt  = st_r.cnt + {3'h0, push} - {3'h0, pop};
    st_nxt.rx_v = pop;
    st_nxt.rx_d = pop ? st_r.mem[st_r.rp] : st_r.rx_d;
    if (rx_drst) begin
      st_nxt.wp   = '0;
      st_nxt.rp   = '0;
      st_nxt.cnt  = '0;
      st_nxt.rx_v = 1'b0;
      st_nxt.rx_d = '0;
    end
    // a depth change leaves stale pointers, so drain on mode writes
    if (reg_wr && reg_addr == CTRL_OFS &&
        reg_wdata[CTRL_MODE_LSB +: 2] != st_r.ctrl[CTRL_MODE_LSB +: 2]) begin
      st_nxt.wp  = '0;
      st_nxt.rp  = '0;
      st_nxt.cnt = '0;
    end

    // transmit output buffer source
    unique case (st_r.lb)
      LB_PRE_CDR: st_nxt.tx_out = rx_serial_in;
      LB_REV_SER: st_nxt.tx_out = st_r.clock_recovery_unit;
      default:    st_nxt.tx_out = st_r.ser;
    endcase
    // buffer stays on in every loopback; only block shutdown turns it off
    st_nxt.tx_oe  = !blk_off;
    st_nxt.pe_out = (st_r.lb == LB_PRE_CDR) ? 4'h0 : st_r.preemph;
    if (blk_off) st_nxt.tx_out = '0;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_r      <= '0;
      st_r.ctrl <= CTRL_RESET;
      st_r.lb   <= LB_NONE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata     = st_r.rdata;
  assign tx_serial_out = st_r.tx_out;
  assign tx_buf_oe     = st_r.tx_oe;
  assign tx_preemph    = st_r.pe_out;
  assign rx_data       = st_r.rx_d;
  assign rx_valid      = st_r.rx_v;
  // calibration powerdown is passed through; using it mid-traffic corrupts data
  assign cal_powerdown = st_r.ctrl[CTRL_CAL_PD_BIT];

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  logic [1:0] md_c;
  assign md_c = st_r.ctrl[CTRL_MODE_LSB +: 2];

  sequence s_ser_req;
    (md_c == MODE_GIGE || md_c == MODE_SRIO) && st_r.ctrl[CTRL_SER_LPBK_BIT]
      && !st_r.ctrl[CTRL_PRE_CDR_BIT] && !st_r.ctrl[CTRL_REV_SER_BIT];
  endsequence
  sequence s_ser_seen;
    ##1 st_r.lb == LB_SERIAL;
  endsequence

  a_serial_enter: assert property (s_ser_req |-> s_ser_seen)
    else $error("serial loopback not entered");
  a_serial_leave: assert property (!st_r.ctrl[CTRL_SER_LPBK_BIT] |=> st_r.lb != LB_SERIAL)
    else $error("serial loopback held without enable");
  a_serial_cru_src: assert property (st_r.lb == LB_SERIAL && !rx_arst
      |=> st_r.clock_recovery_unit == $past(st_r.ser))
    else $error("clock recovery not fed from serializer");
  a_tx_buf_on: assert property (st_r.lb == LB_SERIAL && !blk_off
      |=> tx_buf_oe && tx_serial_out == $past(st_r.ser))
    else $error("transmit buffer idle in serial loopback");
  a_rev_ser_path: assert property (st_r.lb == LB_REV_SER && !blk_off
      |=> tx_serial_out == $past(st_r.clock_recovery_unit))
    else $error("reverse serial path wrong");
  a_precdr_path: assert property (st_r.lb == LB_PRE_CDR && !blk_off
      |=> tx_serial_out == $past(rx_serial_in) && tx_preemph == 4'h0)
    else $error("pre-cdr loopback path wrong");
  a_revpar_pipe: assert property (st_r.lb == LB_REV_PAR
      |-> $past(md_c) == MODE_PIPE
          && $past(st_r.ctrl[CTRL_PSTATE_LSB +: 2]) == PSTATE_P0)
    else $error("reverse parallel loopback outside pipe p0");
  a_revpar_ser: assert property (st_r.lb == LB_REV_PAR && !blk_off
      |=> st_r.ser == $past(st_r.rm) ##1 tx_serial_out == $past(st_r.rm, 2))
    else $error("rate matcher not feeding serializer");
  a_revpar_fabric: assert property (!rx_drst && st_r.rm_v
      |=> st_r.dec_v && st_r.dec == $past(st_r.rm))
    else $error("rate matcher output not reaching fabric");
  a_reset_split: assert property (st_r.ctrl[CTRL_RX_ANA_RST_BIT] && !blk_off
      && !st_r.ctrl[CTRL_TX_DIG_RST_BIT] && tx_valid |=> st_r.txp_v && !st_r.cru_v)
    else $error("resets not independent");
  a_block_off: assert property (blk_off |=> !tx_buf_oe ##1 !rx_valid)
    else $error("block not shut down");
  a_fifo_depth: assert property (st_r.cnt <= depth)
    else $error("phase fifo exceeds depth");
endmodule : tlrc_top

// ### verification/tlrc_line_model.sv
// far-side line source: feeds receive words into the channel
// assumes the bench drives line_en by non-blocking assignment at rising edges
`timescale 1ns/1ps
module tlrc_line_model #(
  parameter int W = 10
) (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic         line_en,
  output logic [W-1:0]      rx_word,
  output logic              rx_word_valid
);
  logic [W-1:0] cnt_r;
  // idle line keeps toggling so a stale word never looks fresh
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cnt_r         <= '0;
      rx_word       <= '0;
      rx_word_valid <= 1'b0;
    end else if (line_en) begin
      cnt_r         <= cnt_r + 1'b1;
      rx_word       <= cnt_r;
      rx_word_valid <= 1'b1;
    end else begin
      rx_word       <= ~rx_word;
      rx_word_valid <= 1'b0;
    end
  end
endmodule : tlrc_line_model

// ### verification/tb_tlrc_top.sv
// self-checking bench for the loopback and reset controller
// assumes the line model on the receive side and the plain register port
`timescale 1ns/1ps
module tb_tlrc_top;
  import tlrc_pkg::*;
  localparam int W = 10;
  logic core_clk, reset, reg_wr, reg_rd, tx_valid, rx_serial_valid, rx_ready, tx_buf_oe;
  logic rx_valid, cal_powerdown, line_en;
  logic [7:0]   reg_addr;
  logic [31:0]  reg_wdata, reg_rdata, rd_v;
  logic [W-1:0] tx_data, rx_serial_in, tx_serial_out, rx_data;
  logic [3:0]   tx_preemph;
  int n_errors, n_tests, pops;
  tlrc_top #(.W(W)) dut_u (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_data(tx_data), .tx_valid(tx_valid), .rx_serial_in(rx_serial_in),
    .rx_serial_valid(rx_serial_valid), .tx_serial_out(tx_serial_out), .tx_buf_oe(tx_buf_oe),
    .tx_preemph(tx_preemph), .rx_ready(rx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .cal_powerdown(cal_powerdown));
  tlrc_line_model #(.W(W)) line_u (.core_clk(core_clk), .reset(reset), .line_en(line_en),
    .rx_word(rx_serial_in), .rx_word_valid(rx_serial_valid));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) tx_data <= tx_data + 1'b1;
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : reg_write
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read
  // block enable kept on, all channel resets released
  function automatic logic [31:0] ctl(input logic [1:0] mode, input logic [31:0] extra);
    return {30'h0, mode} | (32'h1 << CTRL_BLK_ENABLE_BIT) | extra;
  endfunction : ctl
  task automatic lb_is(input tlrc_lb_e exp);
    reg_read(STATUS_OFS, rd_v);
    check("loopback", {29'h0, rd_v[2:0]}, {29'h0, exp});
  endtask : lb_is
  // word present before one edge must show n edges later
  task automatic lat(input bit from_tx, input int n);
    logic [W-1:0] v;
    @(posedge core_clk);
    v = from_tx ? tx_data : rx_serial_in;
    repeat (n - 1) @(posedge core_clk);
    #1 check("line word", 32'(tx_serial_out), 32'(v));
  endtask : lat
  task automatic fifo_is(input logic [3:0] cnt, input logic ovf);
    reg_read(STATUS_OFS, rd_v);
    check("fifo count", {28'h0, rd_v[7:4]}, {28'h0, cnt});
    check("overflow", {31'h0, rd_v[9]}, {31'h0, ovf});
  endtask : fifo_is
  task automatic conclude;
    if (n_errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  initial begin
    #200000;
    n_errors++;
    conclude();
  end
  initial begin
    {reg_wr, reg_rd, rx_ready, line_en, reg_addr, reg_wdata, tx_data} = '0;
    tx_valid = 1'b1;
    reset = 1'b1;
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    reg_read(CTRL_OFS, rd_v);
    check("ctrl reset", rd_v, 32'h0000_1700);
    reg_read(STATUS_OFS, rd_v);
    check("oe status", {31'h0, rd_v[8]}, 32'h1);
    line_en <= 1'b1;
    reg_write(CTRL_OFS, ctl(MODE_GIGE, 0));
    lat(1'b1, 3);
    reg_write(PREEMPH_OFS, 32'h5);
    check("preemph", {28'h0, tx_preemph}, 32'h5);
    reg_write(CTRL_OFS, ctl(MODE_GIGE, 32'h1 << CTRL_SER_LPBK_BIT));
    lb_is(LB_SERIAL);
    check("oe in serial", {31'h0, rd_v[8]}, 32'h1);
    check("oe pin", {31'h0, tx_buf_oe}, 32'h1);
    reg_write(CTRL_OFS, ctl(MODE_SRIO, 32'h1 << CTRL_SER_LPBK_BIT));
    lb_is(LB_SERIAL);
    reg_write(CTRL_OFS, ctl(MODE_SRIO, 0));
    lb_is(LB_NONE);
    reg_write(CTRL_OFS, ctl(MODE_GIGE, 32'h1 << CTRL_DETRX_LPBK_BIT));
    lb_is(LB_NONE);
    reg_write(CTRL_OFS, ctl(MODE_PIPE, 32'h1 << CTRL_DETRX_LPBK_BIT));
    lb_is(LB_REV_PAR);
    lat(1'b0, 4);
    reg_write(CTRL_OFS, ctl(MODE_PIPE, 32'ha0));
    lb_is(LB_NONE);
    reg_write(CTRL_OFS, ctl(MODE_GIGE, 32'h1 << CTRL_REV_SER_BIT));
    lb_is(LB_REV_SER);
    lat(1'b0, 2);
    reg_write(CTRL_OFS, ctl(MODE_GIGE, 32'h18));
    lb_is(LB_PRE_CDR);
    lat(1'b0, 1);
    check("preemph pre-cdr", {28'h0, tx_preemph}, 32'h0);
    // receive fifo fills with the fabric stalled, then overflows
    reg_write(CTRL_OFS, ctl(MODE_GIGE, 0));
    repeat (20) @(posedge core_clk);
    line_en <= 1'b0;
    // let words still in the receive pipe land before the flag is cleared
    repeat (6) @(posedge core_clk);
    fifo_is(FIFO_DEPTH_OTHER, 1'b1);
    reg_write(STATUS_OFS, 32'h1 << STAT_OVF_BIT);
    fifo_is(FIFO_DEPTH_OTHER, 1'b0);
    reg_write(CTRL_OFS, ctl(MODE_PIPE, 0));
    line_en <= 1'b1;
    repeat (20) @(posedge core_clk);
    line_en <= 1'b0;
    repeat (6) @(posedge core_clk);
    fifo_is(FIFO_DEPTH_PIPE, 1'b1);
    rx_ready <= 1'b1;
    pops = 0;
    repeat (30) begin
      @(posedge core_clk);
      #1 if (rx_valid === 1'b1) pops++;
    end
    check("pops", 32'(pops), 32'(FIFO_DEPTH_PIPE));
    rx_ready <= 1'b0;
    line_en <= 1'b1;
    repeat (20) @(posedge core_clk);
    line_en <= 1'b0;
    reg_write(CTRL_OFS, ctl(MODE_PIPE, 32'h1 << CTRL_RX_DIG_RST_BIT));
    reg_read(STATUS_OFS, rd_v);
    check("fifo after rx reset", {28'h0, rd_v[7:4]}, 32'h0);
    // receive analog reset alone: transmit still flows, nothing reaches the fifo
    reg_write(CTRL_OFS, ctl(MODE_GIGE, 32'h1 << CTRL_RX_ANA_RST_BIT));
    line_en <= 1'b1;
    lat(1'b1, 3);
    repeat (6) @(posedge core_clk);
    fifo_is(4'h0, 1'b1);
    line_en <= 1'b0;
    reg_write(CTRL_OFS, ctl(MODE_GIGE, 32'h1 << CTRL_POWERDOWN_BIT));
    check("oe powerdown", {31'h0, tx_buf_oe}, 32'h0);
    reg_write(CTRL_OFS, 32'h0);
    check("oe disabled", {31'h0, tx_buf_oe}, 32'h0);
    reg_write(CTRL_OFS, ctl(MODE_GIGE, 32'h1 << CTRL_CAL_PD_BIT));
    check("oe restored", {31'h0, tx_buf_oe}, 32'h1);
    check("cal pd", {31'h0, cal_powerdown}, 32'h1);
    reg_read(8'h10, rd_v);
    check("unmapped", rd_v, 32'h0);
    conclude();
  end
endmodule : tb_tlrc_top
